// [src/upf_pin_bank.sv]
// pin personality selection and register bank decode for the serial controller
// assumes host strobes, timing unit and serial machines run on clk; pins are asynchronous
//
// What this block does
// (RULE_01) transmit pin carries the tx machine bit stream, least significant bit first
// (RULE_02) receive pin is synchronised and handed on in arrival order, lsb first
// (RULE_03) ring pin reads as active-low input or feeds rx/tx serial clocks
// (RULE_04) terminal-ready in gen B role outputs timer pulse or generator clock
// (RULE_05) terminal-ready in modem role is an active-low cpu output
// (RULE_06) set-ready pin: active-low input, generator A output, or cpu output
// (RULE_07) request-to-send is cpu output; in auto mode it also follows pending data
// (RULE_08) request-to-send is an input through reset and picks the clock mode
// (RULE_09) clear-to-send gates transmission in auto mode, else a plain input
// (RULE_10) carrier-detect pin: active-low input, system clock echo, or cpu output; the echo here is the system clock halved
// (RULE_11) six blocks other than the bus unit raise block interrupt requests
// (RULE_12) rx machine, timer and modem have maskable second-level sources
// (RULE_13) each fifo has its own threshold that raises a request
// (RULE_14) clock from crystal or external clock; two rate generators supported
// (RULE_15) host port: 8-bit data, 3-bit address, read, write, select, interrupt
// (RULE_16) register chosen by three address lines plus bank pointer
// (RULE_17) four banks, only the selected bank is reachable
// (RULE_18) two bank bits: 0 legacy, 1 work, 2 config, 3 modem config
// (RULE_19) bank pointer selects legacy bank at power-up
// (RULE_20) wake-up mode: legacy bank visible, other registers at legacy defaults
// (RULE_21) reset returns the block to wake-up mode
// (RULE_22) request-to-send pulled high in reset; low strap selects crystal
// (RULE_23) far end may strap terminal-ready low, never both straps
// (RULE_24) second oscillator pin is cpu output only with external clock
// (RULE_25) multifunction pins drive only when an output function is chosen
// (RULE_26) pins default to modem roles, second oscillator pin to cpu output
module upf_pin_bank
	import upf_pkg::*;
(
	// clock and reset
	input  wire logic                clk,
	input  wire logic                resetn,
	// host port
	input  wire upf_host_req_t       host,
	output logic [DATA_W-1:0]        rdata,
	output logic                     rdata_oe,
	output logic                     irq,
	// block sources
	input  wire logic [2:0]          rx_fifo_level,
	input  wire logic [2:0]          tx_fifo_level,
	input  wire logic [6:0]          rx_src,
	input  wire logic                tx_mach_req,
	input  wire logic [1:0]          tmr_src,
	input  wire logic [3:0]          mdm_src,
	// timing unit
	input  wire logic                gen_a_timer_mode,
	input  wire logic                gen_a_clk,
	input  wire logic                gen_a_expired,
	input  wire logic                gen_b_timer_mode,
	input  wire logic                gen_b_clk,
	input  wire logic                gen_b_expired,
	output logic                     crystal_mode,
	output logic                     div2_off,
	output logic                     rx_sclk,
	output logic                     tx_sclk,
	// serial machines
	input  wire logic                tx_bit,
	input  wire logic                tx_pending,
	output logic                     rx_bit,
	output logic                     tx_enable,
	// pins
	output logic                     txd,
	input  wire logic                rxd,
	input  wire logic                bell_alert_in_n,
	input  wire logic                cts_n,
	input  wire logic                dtr_in,
	output upf_pin_t                 dtr_pin,
	input  wire logic                dsr_in,
	output upf_pin_t                 dsr_pin,
	input  wire logic                rts_in,
	output upf_pin_t                 rts_pin,
	input  wire logic                carrier_detect_in,
	output upf_pin_t                 dcd_pin,
	output upf_pin_t                 crystal_drive_out
);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_reg;
	logic       rst_n;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end

	assign rst_n = rst_sync_reg[1];

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic any_on(input logic [7:0] src, input logic [7:0] en);
		return |(src & en);
	endfunction

	function automatic logic [2:0] first_set(input logic [5:0] v);
		logic [2:0] code;
		code = 3'h0;
		for (int i = 5; i >= 0; i--)
		begin
			if (v[i])
				code = 3'(i);
		end
		return code;
	endfunction

	function automatic logic pick_gen(input logic timer, input logic pulse, input logic gclk);
		return timer ? pulse : gclk;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	upf_state_t      st_reg;
	upf_state_t      st_next;
	logic [N_IN-1:0] pin_raw;
	logic [5:0]      blk_req;
	logic [5:0]      masked;
	logic [4:0]      idx;
	logic            sel_w;
	logic            sel_r;
	logic [1:0]      dsr_fn;
	logic [1:0]      dcd_fn;

	assign pin_raw[IN_RXD] = rxd;
	assign pin_raw[IN_RI]  = bell_alert_in_n;
	assign pin_raw[IN_DSR] = dsr_in;
	assign pin_raw[IN_RTS] = rts_in;
	assign pin_raw[IN_CTS] = cts_n;
	assign pin_raw[IN_DCD] = carrier_detect_in;
	assign pin_raw[IN_DTR] = dtr_in;

	assign idx    = {st_reg.bank, host.addr}; // RULE_16
	assign sel_w  = !host.cs_n && host.wr; // RULE_15
	assign sel_r  = !host.cs_n && host.rd;
	assign dsr_fn = st_reg.pin_mode[PM_DSR_LSB +: 2];
	assign dcd_fn = st_reg.pin_mode[PM_DCD_LSB +: 2];

	// ----------------------------------------------------------------
	// block requests
	// ----------------------------------------------------------------
	// index order: rx fifo, tx fifo, rx machine, tx machine, timer, modem
	assign blk_req[0] = rx_fifo_level >= st_reg.rx_thr; // RULE_13
	assign blk_req[1] = tx_fifo_level <= st_reg.tx_thr; // RULE_13
	assign blk_req[2] = any_on({1'b0, rx_src}, {1'b0, st_reg.rx_en}); // RULE_12
	assign blk_req[3] = tx_mach_req; // RULE_11
	assign blk_req[4] = any_on({6'h00, tmr_src}, {6'h00, st_reg.tmr_en}); // RULE_12
	assign blk_req[5] = any_on({4'h0, mdm_src}, {4'h0, st_reg.mdm_en}); // RULE_12
	assign masked     = blk_req & st_reg.gen_en; // RULE_11

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		st_next = st_reg;
		// first stage feeds only the second stage
		st_next.meta = pin_raw;
		st_next.pins = st_reg.meta;

		// straps are read once the synchronised pins have settled after release
		if (!st_reg.strap_done)
		begin
			if (st_reg.strap_cnt == STRAP_WAIT)
			begin
				st_next.strap_done   = 1'b1;
				st_next.crystal_mode = !st_reg.pins[IN_RTS]; // RULE_08 RULE_22 RULE_14
				st_next.div2_off     = !st_reg.pins[IN_DTR]; // RULE_23
			end
			else
			begin
				st_next.strap_cnt = st_reg.strap_cnt + 2'h1;
			end
		end

		// register writes
		if (sel_w)
		begin
			if (host.addr == ADDR_BANK)
			begin
				st_next.bank = host.wdata[BANK_LSB +: 2]; // RULE_18
			end
			else
			begin
				case (idx) // RULE_17
					REG_GEN_EN:  st_next.gen_en   = host.wdata[5:0];
					REG_MCTL:    st_next.mctl     = host.wdata[4:0];
					REG_TXMODE:  st_next.auto_tx  = host.wdata[0];
					REG_THRESH:
					begin
						st_next.rx_thr = host.wdata[THR_RX_LSB +: 3];
						st_next.tx_thr = host.wdata[THR_TX_LSB +: 3];
					end
					REG_RX_EN:   st_next.rx_en    = host.wdata[6:0];
					REG_TMR_EN:  st_next.tmr_en   = host.wdata[1:0];
					REG_PINMODE: st_next.pin_mode = host.wdata;
					REG_MDM_EN:  st_next.mdm_en   = host.wdata[3:0];
					default:     st_next.mctl     = st_reg.mctl;
				endcase
			end
		end

		// register reads, data stands one cycle only
		st_next.rdata_oe = sel_r;
		st_next.rdata    = 8'h00;
		if (sel_r)
		begin
			if (host.addr == ADDR_BANK)
			begin
				st_next.rdata = {1'b0, st_reg.bank, 1'b0, first_set(masked), !(|masked)};
			end
			else
			begin
				case (idx) // RULE_17 RULE_20
					REG_GEN_EN:  st_next.rdata = {2'h0, st_reg.gen_en};
					REG_MCTL:    st_next.rdata = {3'h0, st_reg.mctl};
					REG_MSTAT:
					begin
						// inputs are active low, reported as asserted-high
						st_next.rdata = {4'h0, !st_reg.pins[IN_DCD], !st_reg.pins[IN_RI],
							!st_reg.pins[IN_DSR], !st_reg.pins[IN_CTS]}; // RULE_03 RULE_06 RULE_09 RULE_10
					end
					REG_TXMODE:  st_next.rdata = {7'h00, st_reg.auto_tx};
					REG_THRESH:  st_next.rdata = {1'b0, st_reg.tx_thr, 1'b0, st_reg.rx_thr};
					REG_BLKSTAT: st_next.rdata = {2'h0, blk_req};
					REG_RX_EN:   st_next.rdata = {1'b0, st_reg.rx_en};
					REG_TMR_EN:  st_next.rdata = {6'h00, st_reg.tmr_en};
					REG_PINMODE: st_next.rdata = st_reg.pin_mode;
					REG_MDM_EN:  st_next.rdata = {4'h0, st_reg.mdm_en};
					REG_STRAP:   st_next.rdata = {6'h00, st_reg.div2_off, st_reg.crystal_mode};
					default:     st_next.rdata = 8'h00;
				endcase
			end
		end

		st_next.irq = |masked; // RULE_11

		// serial data path
		st_next.txd    = tx_bit; // RULE_01
		st_next.echo   = !st_reg.echo;
		st_next.rx_sclk = st_reg.pin_mode[PM_SCLK_RX] & st_reg.pins[IN_RI]; // RULE_03
		st_next.tx_sclk = st_reg.pin_mode[PM_SCLK_TX] & st_reg.pins[IN_RI]; // RULE_03
		st_next.tx_enable = !st_reg.auto_tx || !st_reg.pins[IN_CTS]; // RULE_09

		// terminal-ready: both roles drive, but not before the strap is taken
		st_next.dtr.oe = st_reg.strap_done; // RULE_25
		if (st_reg.pin_mode[PM_DTR])
			st_next.dtr.o = pick_gen(gen_b_timer_mode, gen_b_expired, gen_b_clk); // RULE_04
		else
			st_next.dtr.o = !st_reg.mctl[MC_DTR]; // RULE_05

		// request-to-send stays released until the clock strap has been read
		st_next.rts.oe = st_reg.strap_done; // RULE_08
		st_next.rts.o  = !(st_reg.mctl[MC_RTS] || (st_reg.auto_tx && tx_pending)); // RULE_07

		// set-ready
		case (dsr_fn) // RULE_06 RULE_25
			FN_TIMING:
			begin
				st_next.dsr.oe = 1'b1;
				st_next.dsr.o  = pick_gen(gen_a_timer_mode, gen_a_expired, gen_a_clk);
			end
			FN_GPOUT:
			begin
				st_next.dsr.oe = 1'b1;
				st_next.dsr.o  = !st_reg.mctl[MC_SPARE_OUT_ZERO];
			end
			default:
			begin
				st_next.dsr.oe = 1'b0;
				st_next.dsr.o  = 1'b1;
			end
		endcase

		// carrier-detect; the echo is the system clock halved, the best a flop can give
		case (dcd_fn) // RULE_10 RULE_25
			FN_TIMING:
			begin
				st_next.dcd.oe = 1'b1;
				st_next.dcd.o  = !st_reg.echo;
			end
			FN_GPOUT:
			begin
				st_next.dcd.oe = 1'b1;
				st_next.dcd.o  = !st_reg.mctl[MC_SPARE_OUT_ONE];
			end
			default:
			begin
				st_next.dcd.oe = 1'b0;
				st_next.dcd.o  = 1'b1;
			end
		endcase

		// with a crystal the pin belongs to the oscillator pad
		st_next.x2.oe = st_reg.strap_done && !st_reg.crystal_mode; // RULE_24
		st_next.x2.o  = !st_reg.mctl[MC_SPARE_OUT_TWO];
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st_reg <= ST_RESET; // RULE_19 RULE_20 RULE_21 RULE_26
		else
			st_reg <= st_next;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign rdata             = st_reg.rdata;
	assign rdata_oe          = st_reg.rdata_oe;
	assign irq               = st_reg.irq;
	assign crystal_mode      = st_reg.crystal_mode;
	assign div2_off          = st_reg.div2_off;
	assign rx_sclk           = st_reg.rx_sclk;
	assign tx_sclk           = st_reg.tx_sclk;
	assign rx_bit            = st_reg.pins[IN_RXD]; // RULE_02
	assign tx_enable         = st_reg.tx_enable;
	assign txd               = st_reg.txd;
	assign dtr_pin           = st_reg.dtr;
	assign dsr_pin           = st_reg.dsr;
	assign rts_pin           = st_reg.rts;
	assign dcd_pin           = st_reg.dcd;
	assign crystal_drive_out = st_reg.x2;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	bank_write_a: assert property ( // RULE_18
		sel_w && host.addr == ADDR_BANK |=> st_reg.bank == $past(host.wdata[6:5]))
		else $error("bank pointer not taken from write");

	read_slot_a: assert property ( // RULE_15
		sel_r |=> rdata_oe ##1 (!rdata_oe || $past(sel_r)))
		else $error("read data not one cycle after read");

	strap_float_a: assert property ( // RULE_08
		!st_reg.strap_done |-> !rts_pin.oe && !dtr_pin.oe)
		else $error("strap pin driven before sampling");

	cts_gate_a: assert property ( // RULE_09
		st_reg.auto_tx && st_reg.pins[IN_CTS] ##1 st_reg.auto_tx |-> !tx_enable)
		else $error("transmit not held by clear-to-send");

	gen_b_pin_a: assert property ( // RULE_04
		st_reg.pin_mode[PM_DTR] && gen_b_timer_mode && st_reg.strap_done
			|=> dtr_pin.o == $past(gen_b_expired))
		else $error("terminal-ready not carrying timer pulse");

	dsr_input_a: assert property ( // RULE_25
		dsr_fn == FN_MODEM |=> !dsr_pin.oe)
		else $error("set-ready driven in input role");

	dcd_echo_a: assert property ( // RULE_10
		dcd_fn == FN_TIMING ##1 dcd_fn == FN_TIMING |=> dcd_pin.o != $past(dcd_pin.o))
		else $error("clock echo not toggling");

	irq_follow_a: assert property ( // RULE_11
		|masked |=> irq)
		else $error("masked request did not raise interrupt");

	x2_crystal_a: assert property ( // RULE_24
		st_reg.crystal_mode |=> !crystal_drive_out.oe)
		else $error("oscillator pin driven in crystal mode");

endmodule

// [src/upf_pkg.sv]
// constants and types for the pin function and bank select block
// assumes one 20 MHz system clock shared with the host port and the timing unit
package upf_pkg;

	// ----------------------------------------------------------------
	// bus shape and bank codes
	// ----------------------------------------------------------------
	localparam int        ADDR_W      = 3;
	localparam int        DATA_W      = 8;
	localparam logic [1:0] BANK_LEGACY = 2'h0;
	localparam logic [1:0] BANK_WORK   = 2'h1;
	localparam logic [1:0] BANK_GCFG   = 2'h2;
	localparam logic [1:0] BANK_MCFG   = 2'h3;
	localparam int        BANK_LSB    = 5;

	// ----------------------------------------------------------------
	// register indices {bank, address}
	// ----------------------------------------------------------------
	localparam logic [2:0] ADDR_BANK   = 3'h2;
	localparam logic [4:0] REG_GEN_EN  = 5'h01;
	localparam logic [4:0] REG_MCTL    = 5'h04;
	localparam logic [4:0] REG_MSTAT   = 5'h06;
	localparam logic [4:0] REG_TXMODE  = 5'h08;
	localparam logic [4:0] REG_THRESH  = 5'h09;
	localparam logic [4:0] REG_BLKSTAT = 5'h0B;
	localparam logic [4:0] REG_RX_EN   = 5'h10;
	localparam logic [4:0] REG_TMR_EN  = 5'h11;
	localparam logic [4:0] REG_PINMODE = 5'h18;
	localparam logic [4:0] REG_MDM_EN  = 5'h19;
	localparam logic [4:0] REG_STRAP   = 5'h1B;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int MC_DTR     = 0;
	localparam int MC_RTS     = 1;
	localparam int MC_SPARE_OUT_ZERO    = 2;
	localparam int MC_SPARE_OUT_ONE    = 3;
	localparam int MC_SPARE_OUT_TWO    = 4;
	localparam int PM_SCLK_RX = 0;
	localparam int PM_DSR_LSB = 1;
	localparam int PM_DCD_LSB = 3;
	localparam int PM_DTR     = 5;
	localparam int PM_SCLK_TX = 6;
	localparam int THR_RX_LSB = 0;
	localparam int THR_TX_LSB = 4;
	localparam logic [1:0] FN_MODEM  = 2'h0;
	localparam logic [1:0] FN_TIMING = 2'h1;
	localparam logic [1:0] FN_GPOUT  = 2'h2;

	// synchronised pin inputs
	localparam int IN_RXD = 0;
	localparam int IN_RI  = 1;
	localparam int IN_DSR = 2;
	localparam int IN_RTS = 3;
	localparam int IN_CTS = 4;
	localparam int IN_DCD = 5;
	localparam int IN_DTR = 6;
	localparam int N_IN   = 7;

	// ----------------------------------------------------------------
	// reset values and timing
	// ----------------------------------------------------------------
	localparam logic [6:0] RX_EN_RST  = 7'h0F;
	localparam logic [1:0] TMR_EN_RST = 2'h0;
	localparam logic [3:0] MDM_EN_RST = 4'hF;
	localparam logic [2:0] RX_THR_RST = 3'h1;
	localparam logic [2:0] TX_THR_RST = 3'h0;
	localparam logic [1:0] STRAP_WAIT = 2'h3;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              cs_n;
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} upf_host_req_t;

	typedef struct packed {
		logic o;
		logic oe;
	} upf_pin_t;

	typedef struct packed {
		logic [N_IN-1:0] meta;
		logic [N_IN-1:0] pins;
		logic [1:0]      strap_cnt;
		logic            strap_done;
		logic            crystal_mode;
		logic            div2_off;
		logic [1:0]      bank;
		logic [5:0]      gen_en;
		logic [4:0]      mctl;
		logic            auto_tx;
		logic [2:0]      rx_thr;
		logic [2:0]      tx_thr;
		logic [6:0]      rx_en;
		logic [1:0]      tmr_en;
		logic [3:0]      mdm_en;
		logic [7:0]      pin_mode;
		logic [7:0]      rdata;
		logic            rdata_oe;
		logic            irq;
		logic            echo;
		logic            txd;
		logic            tx_enable;
		logic            rx_sclk;
		logic            tx_sclk;
		upf_pin_t        dtr;
		upf_pin_t        dsr;
		upf_pin_t        rts;
		upf_pin_t        dcd;
		upf_pin_t        x2;
	} upf_state_t;

	localparam upf_state_t ST_RESET = '{
		meta:   7'h7F,
		pins:   7'h7F,
		rx_en:  RX_EN_RST,
		tmr_en: TMR_EN_RST,
		mdm_en: MDM_EN_RST,
		rx_thr: RX_THR_RST,
		tx_thr: TX_THR_RST,
		txd:    1'b1,
		dtr:    2'h2,
		dsr:    2'h2,
		rts:    2'h2,
		dcd:    2'h2,
		x2:     2'h2,
		default: '0
	};

endpackage

// [test/upf_modem_far.sv]
// far-side model of the modem lines on the shared pins
// assumes the bench sets straps and line levels; at most one strap at a time
module upf_modem_far
	import upf_pkg::*;
(
	// straps and idle line levels
	input  wire logic		strap_rts,
	input  wire logic		strap_dtr,
	input  wire logic		dsr_lvl,
	input  wire logic		dcd_lvl,
	// pins as driven by the block
	input  wire upf_pin_t	rts_pin,
	input  wire upf_pin_t	dtr_pin,
	input  wire upf_pin_t	dsr_pin,
	input  wire upf_pin_t	dcd_pin,
	// resolved wire levels
	output logic			rts_in,
	output logic			dtr_in,
	output logic			dsr_in,
	output logic			carrier_detect_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// a released rts or dtr line falls to its strap resistor or the weak pull-up; dsr and dcd take the bench line level
	assign rts_in = rts_pin.oe ? rts_pin.o : !strap_rts;
	assign dtr_in = dtr_pin.oe ? dtr_pin.o : !strap_dtr;
	assign dsr_in = dsr_pin.oe ? dsr_pin.o : dsr_lvl;
	assign carrier_detect_in = dcd_pin.oe ? dcd_pin.o : dcd_lvl;
endmodule

// [test/testbench.sv]
// self-checking bench for the pin function and bank select block
// assumes a 20 MHz clock and the far-side modem model beside the design
module testbench
	import upf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic			clk = 1'b0;
	logic			resetn = 1'b0;
	upf_host_req_t	host = '{cs_n: 1'b1, default: '0};
	logic [7:0]		rdata;
	logic			rdata_oe, irq, crystal_mode, div2_off, rx_sclk, tx_sclk, rx_bit, tx_enable, txd, e;
	logic [2:0]		rx_fifo_level = 3'h0;
	logic [3:0]		mdm_src = 4'h0;
	logic [1:0]		tmr_src = 2'h0;
	logic			gen_a_clk = 1'b0, gen_b_clk = 1'b0, gen_b_timer_mode = 1'b0, gen_b_expired = 1'b0;
	logic			tx_bit = 1'b1, tx_pending = 1'b0, rxd = 1'b1, bell_alert_in_n = 1'b1, cts_n = 1'b1;
	logic			strap_rts = 1'b0, strap_dtr = 1'b0, dsr_lvl = 1'b1, dcd_lvl = 1'b1;
	logic			rts_in, dtr_in, dsr_in, carrier_detect_in;
	upf_pin_t		dtr_pin, dsr_pin, rts_pin, dcd_pin, crystal_drive_out;
	logic [7:0]		d = 8'hA5;
	int				errors = 0;
	int				cmp_count = 0;

	always #25 clk = ~clk;

	upf_pin_bank u_upf_pin_bank (
		.clk, .resetn, .host, .rdata, .rdata_oe, .irq, .rx_fifo_level,
		.tx_fifo_level(3'h7), .rx_src(7'h00), .tx_mach_req(1'b0), .tmr_src, .mdm_src,
		.gen_a_timer_mode(gen_b_timer_mode), .gen_a_clk, .gen_a_expired(gen_b_expired),
		.gen_b_timer_mode, .gen_b_clk, .gen_b_expired, .crystal_mode, .div2_off, .rx_sclk,
		.tx_sclk, .tx_bit, .tx_pending, .rx_bit, .tx_enable, .txd, .rxd, .bell_alert_in_n,
		.cts_n, .dtr_in, .dtr_pin, .dsr_in, .dsr_pin, .rts_in, .rts_pin,
		.carrier_detect_in, .dcd_pin, .crystal_drive_out
	);

	upf_modem_far u_upf_modem_far (
		.strap_rts, .strap_dtr, .dsr_lvl, .dcd_lvl, .rts_pin, .dtr_pin, .dsr_pin,
		.dcd_pin, .rts_in, .dtr_in, .dsr_in, .carrier_detect_in
	);

	// ----
	// checking and bus tasks
	// ----
	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic put(input logic w, input logic r, input logic [2:0] a, input logic [7:0] v);
		@(posedge clk);
		host <= '{cs_n: !(w | r), wr: w, rd: r, addr: a, wdata: v};
	endtask

	task automatic reg_wr(input logic [1:0] b, input logic [2:0] a, input logic [7:0] v);
		put(1'b1, 1'b0, ADDR_BANK, {1'b0, b, 5'h00});
		put(1'b1, 1'b0, a, v);
		put(1'b0, 1'b0, 3'h0, 8'h00);
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_raw(input logic [2:0] a, input logic [7:0] exp);
		put(1'b0, 1'b1, a, 8'h00);
		put(1'b0, 1'b0, 3'h0, 8'h00);
		#1;
		chk(rdata, exp);
		chk({7'h0, rdata_oe}, 8'h01);
		// the data bus must be released again after its single cycle
		wait_pins(1);
		chk({7'h0, rdata_oe}, 8'h00);
	endtask

	task automatic reg_rd(input logic [1:0] b, input logic [2:0] a, input logic [7:0] exp);
		put(1'b1, 1'b0, ADDR_BANK, {1'b0, b, 5'h00});
		rd_raw(a, exp);
	endtask

	task automatic wait_pins(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// straps are sampled after release; only one strap is ever applied
	task automatic do_reset(input logic s_rts, input logic s_dtr);
		int n;
		n = 0;
		strap_rts <= s_rts;
		strap_dtr <= s_dtr;
		resetn <= 1'b0;
		wait_pins(5);
		chk({6'h0, rts_pin.oe, crystal_drive_out.oe}, 8'h00);
		chk({7'h0, txd}, 8'h01);
		@(posedge clk);
		resetn <= 1'b1;
		while (rts_pin.oe !== 1'b1 && n < 20)
		begin
			wait_pins(1);
			n++;
		end
		if (n == 20)
		begin
			errors++;
			$display("[ERR] %0t strap never completed", $time);
			end_sim();
		end
		#1;
		chk({6'h0, div2_off, crystal_mode}, {6'h0, s_dtr, s_rts});
		chk({5'h0, rts_pin.o, crystal_drive_out.oe, dsr_pin.oe}, {5'h0, 1'b1, !s_rts, 1'b0});
	endtask

	// ----
	// main sequence
	// ----
	initial
	begin
		do_reset(1'b1, 1'b0);
		rd_raw(ADDR_BANK, 8'h01);
		reg_rd(BANK_GCFG, 3'h0, 8'h0F);
		reg_rd(BANK_MCFG, 3'h1, 8'h0F);
		reg_rd(BANK_WORK, 3'h1, 8'h01);
		reg_rd(BANK_MCFG, 3'h3, 8'h01);
		reg_rd(BANK_WORK, 3'h7, 8'h00);
		for (int b = 0; b < 4; b++)
			reg_rd(b[1:0], ADDR_BANK, {1'b0, b[1:0], 5'h01});
		reg_wr(BANK_GCFG, 3'h0, 8'h55);
		reg_rd(BANK_MCFG, 3'h0, 8'h00);
		reg_rd(BANK_GCFG, 3'h0, 8'h55);
		$display("reset and bank test done");

		reg_wr(BANK_LEGACY, 3'h4, 8'h03);
		wait_pins(3);
		chk({4'h0, dtr_pin.oe, rts_pin.oe, dtr_pin.o, rts_pin.o}, 8'h0C);
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clk);
			{dcd_lvl, bell_alert_in_n, dsr_lvl, cts_n} <= i ? 4'b1001 : 4'b0110;
			repeat (4) @(posedge clk);
			reg_rd(BANK_LEGACY, 3'h6, i ? 8'h06 : 8'h09);
		end
		$display("modem line test done");

		reg_wr(BANK_MCFG, 3'h0, 8'h02);
		for (int v = 0; v < 4; v++)
		begin
			@(posedge clk);
			{gen_b_timer_mode, gen_b_expired, gen_a_clk} <= {v[1], v[0], !v[0]};
			wait_pins(3);
			chk({6'h0, dsr_pin.oe, dsr_pin.o}, {6'h0, 1'b1, v[1] ? v[0] : !v[0]});
		end
		reg_wr(BANK_MCFG, 3'h0, 8'h20);
		for (int v = 0; v < 4; v++)
		begin
			@(posedge clk);
			{gen_b_timer_mode, gen_b_expired, gen_b_clk} <= {v[1], v[0], !v[0]};
			wait_pins(3);
			chk({6'h0, dtr_pin.oe, dtr_pin.o}, {6'h0, 1'b1, v[1] ? v[0] : !v[0]});
		end
		reg_wr(BANK_MCFG, 3'h0, 8'h14);
		for (int v = 0; v < 2; v++)
		begin
			reg_wr(BANK_LEGACY, 3'h4, v ? 8'h08 : 8'h04);
			wait_pins(2);
			chk({4'h0, dsr_pin.oe, dcd_pin.oe, dsr_pin.o, dcd_pin.o}, {6'h03, v[0], !v[0]});
		end
		reg_wr(BANK_MCFG, 3'h0, 8'h08);
		wait_pins(3);
		e = dcd_pin.o;
		wait_pins(1);
		chk({6'h0, dcd_pin.oe, dcd_pin.o}, {6'h0, 1'b1, !e});
		reg_wr(BANK_MCFG, 3'h0, 8'h41);
		for (int v = 0; v < 2; v++)
		begin
			@(posedge clk);
			bell_alert_in_n <= v[0];
			wait_pins(4);
			chk({6'h0, rx_sclk, tx_sclk}, {6'h0, v[0], v[0]});
		end
		reg_wr(BANK_MCFG, 3'h0, 8'h00);
		wait_pins(2);
		chk({6'h0, dsr_pin.oe, dcd_pin.oe}, 8'h00);
		$display("pin function test done");

		reg_wr(BANK_WORK, 3'h0, 8'h01);
		for (int v = 0; v < 2; v++)
		begin
			@(posedge clk);
			cts_n <= v[0];
			tx_pending <= 1'b1;
			wait_pins(4);
			chk({6'h0, tx_enable, rts_pin.o}, {6'h0, !v[0], 1'b0});
		end
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk);
			tx_bit <= d[i];
			rxd <= d[i];
			wait_pins(4);
			chk({6'h0, txd, rx_bit}, {6'h0, d[i], d[i]});
		end
		$display("transmit and serial test done");

		@(posedge clk);
		mdm_src <= 4'h1;
		reg_wr(BANK_LEGACY, 3'h1, 8'h20);
		wait_pins(3);
		chk({7'h0, irq}, 8'h01);
		reg_rd(BANK_LEGACY, ADDR_BANK, 8'h0A);
		reg_wr(BANK_MCFG, 3'h1, 8'h00);
		wait_pins(3);
		chk({7'h0, irq}, 8'h00);
		reg_wr(BANK_LEGACY, 3'h1, 8'h01);
		reg_wr(BANK_WORK, 3'h1, 8'h03);
		for (int v = 2; v < 4; v++)
		begin
			@(posedge clk);
			rx_fifo_level <= v[2:0];
			wait_pins(3);
			chk({7'h0, irq}, {7'h0, v == 3});
		end
		@(posedge clk);
		tmr_src <= 2'h2;
		reg_wr(BANK_GCFG, 3'h1, 8'h02);
		reg_wr(BANK_LEGACY, 3'h1, 8'h10);
		reg_rd(BANK_LEGACY, ADDR_BANK, 8'h08);
		$display("interrupt test done");

		reg_wr(BANK_MCFG, 3'h1, 8'h0F);
		do_reset(1'b0, 1'b1);
		rd_raw(ADDR_BANK, 8'h01);
		reg_rd(BANK_LEGACY, 3'h1, 8'h00);
		reg_rd(BANK_MCFG, 3'h3, 8'h02);
		reg_wr(BANK_LEGACY, 3'h4, 8'h10);
		wait_pins(2);
		chk({6'h0, crystal_drive_out.oe, crystal_drive_out.o}, 8'h02);
		$display("second reset test done");
		end_sim();
	end
endmodule
